/* File: pkg/drive_words_pkg.sv */
package drive_words_pkg;

  localparam int WORD_W = 16;
  localparam int TG_W   = 10;

  // Telegram numbers
  localparam logic [TG_W-1:0] TG_STD1  = 10'h001;
  localparam logic [TG_W-1:0] TG_STD20 = 10'h014;
  localparam logic [TG_W-1:0] TG_RESET = TG_STD1;

  // Command word bit positions
  localparam int CMD_ON        = 0;
  localparam int CMD_NO_COAST  = 1;
  localparam int CMD_NO_QUICK  = 2;
  localparam int CMD_ENABLE_OP = 3;
  localparam int CMD_FAULT_ACK = 7;
  localparam int CMD_REVERSE   = 11;
  localparam int CMD_MOP_UP    = 13;
  localparam int CMD_MOP_DOWN  = 14;
  localparam int CMD_CDS0      = 15;

  // State word bit positions
  localparam int ST_READY_START = 0;
  localparam int ST_READY       = 1;
  localparam int ST_OP_ENABLED  = 2;
  localparam int ST_FAULT       = 3;
  localparam int ST_NO_COAST    = 4;
  localparam int ST_NO_QUICK    = 5;
  localparam int ST_LOCKOUT     = 6;
  localparam int ST_ALARM       = 7;
  localparam int ST_SPEED_TOL   = 8;
  localparam int ST_MASTER_REQ  = 9;
  localparam int ST_SPEED_REACH = 10;
  localparam int ST_LIMIT_N     = 11;
  localparam int ST_BRAKE_OPEN  = 12;
  localparam int ST_OVERTEMP_N  = 13;
  localparam int ST_CLOCKWISE   = 14;
  localparam int ST_CDS_OVL     = 15;

  // Reset values and potentiometer limit
  localparam logic [WORD_W-1:0] CMD_RESET   = 16'h0000;
  localparam logic [WORD_W-1:0] STATE_RESET = 16'h0000;
  localparam logic [WORD_W-1:0] SP_RESET    = 16'h0000;
  localparam logic [WORD_W-1:0] MOP_RESET   = 16'h0000;
  localparam logic [WORD_W-1:0] MOP_MAX     = 16'h7fff;
  localparam logic              LOCK_RESET  = 1'b1;

  // Timing
  localparam int CLK_PERIOD_NS   = 20;
  localparam int MOP_STEP_NS     = 10000;
  localparam int MOP_STEP_CYCLES = (MOP_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum {MAP_STD, MAP_T20_FRESH, MAP_T20_KEPT} map_state_t;

  typedef struct packed {
    logic supply_ok;
    logic init_done;
    logic fault_event;
    logic alarm;
    logic master_req;
    logic limit_reached;
    logic brake_open;
    logic motor_overtemp;
    logic inv_overload;
  } drive_flags_t;

  typedef struct packed {
    logic [WORD_W-1:0] setpoint;
    logic [WORD_W-1:0] actual;
    logic [WORD_W-1:0] compare;
    logic [WORD_W-1:0] tolerance;
  } speed_in_t;

  typedef struct packed {
    logic within_tol;
    logic reached;
    logic clockwise;
  } speed_flags_t;

endpackage : drive_words_pkg

/* File: sim/drive_control_status_words_tb.sv */
`timescale 1ns/1ps
module drive_control_status_words_tb;
  localparam int STEP = 4;
  logic                          core_clk = 1'b0;
  logic                          rst_n    = 1'b0;
  logic [15:0]                   command_word;
  logic                          command_valid;
  logic [9:0]                    tsel     = 10'h001;
  logic                          unlock   = 1'b0;
  drive_words_pkg::drive_flags_t flags    = '0;
  drive_words_pkg::speed_in_t    spd      = '0;
  logic [15:0]                   cmd_q, state_q, sp_q, mop_q;
  logic [9:0]                    tg_q;
  logic                          cds_q, energise_q;
  logic                          flt = 1'b0, lk = 1'b1, cw = 1'b1, t20 = 1'b0;
  logic [15:0]                   prev = 16'h0000;
  logic [15:0]                   v;
  int                            n_errors = 0, comparisons = 0;

  always #10 core_clk = ~core_clk;

  plc_model u_plc_model (.core_clk(core_clk), .command_word(command_word),
                         .command_valid(command_valid));

  drive_control_status_words #(.MOP_STEP_CYCLES(STEP)) u_drive_control_status_words (
    .core_clk(core_clk), .rst_n(rst_n), .command_word(command_word),
    .command_valid(command_valid), .telegram_select(tsel), .map_unlock(unlock),
    .drive_flags(flags), .speed(spd), .drive_command_word_one(cmd_q),
    .drive_state_word_one(state_q), .speed_setpoint_out(sp_q),
    .motor_potentiometer_value(mop_q), .active_telegram(tg_q),
    .command_data_set(cds_q), .motor_energise(energise_q));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] exp_sp(logic [15:0] c, logic [15:0] sp);
    if (c[11]) return sp;
    if (sp == 16'h8000) return 16'h7fff;
    return -sp;
  endfunction : exp_sp

  function automatic logic [15:0] exp_state(logic [15:0] c);
    logic [15:0]        s;
    logic signed [16:0] d;
    logic               rdy;
    d = $signed({spd.setpoint[15], spd.setpoint}) - $signed({spd.actual[15], spd.actual});
    if (d < 0) d = -d;
    rdy = flags.supply_ok & flags.init_done & (&c[2:0]) & !flt & !lk;
    s = {!flags.inv_overload, cw, !flags.motor_overtemp, flags.brake_open,
         !flags.limit_reached, 1'b0, flags.master_req, 1'b0, flags.alarm, lk,
         c[2], c[1], flt, rdy & c[3], rdy, flags.supply_ok & flags.init_done};
    s[8] = d <= $signed({1'b0, spd.tolerance});
    s[10] = $signed(spd.actual) >= $signed(spd.compare);
    if (t20) s[15] = c[15];
    return s;
  endfunction : exp_state

  task automatic chk(logic [15:0] got, logic [15:0] exp, string what);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic end_sim();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_sim

  // Send a word, track fault and lockout, compare all outputs except the potentiometer value and active telegram
  task automatic apply(logic [15:0] c, int gap);
    logic [15:0] e;
    u_plc_model.send(c, gap);
    if (c[7] && !prev[7] && flt) begin
      flt = 1'b0;
      if (c[0]) lk = 1'b1;
    end
    if (!c[0]) lk = 1'b0;
    prev = c;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    e = exp_state(c);
    chk(cmd_q, c, "command copy");
    chk(sp_q, exp_sp(c, spd.setpoint), "setpoint");
    chk(state_q & 16'h0007, e & 16'h0007, "ready bits");
    chk(state_q & 16'h0078, e & 16'h0078, "stop bits");
    chk(state_q & 16'h0780, e & 16'h0780, "flag bits");
    chk(state_q & 16'hf800, e & 16'hf800, "high bits");
    chk({15'h0000, energise_q}, {15'h0000, e[2]}, "energise");
    chk({15'h0000, cds_q}, {15'h0000, t20 & c[15]}, "data set");
  endtask : apply

  task automatic rnd_step();
    logic [15:0] c;
    logic [15:0] a;
    a = 16'($urandom);
    if (a == 16'h0000) a = 16'h0001;
    c = 16'($urandom) & 16'hff7f;
    if (c[4]) c[2:0] = 3'b111;
    @(posedge core_clk);
    flags <= drive_words_pkg::drive_flags_t'($urandom) & 9'h1bf;
    spd   <= {16'($urandom), a, 16'($urandom), 16'($urandom) & 16'h0fff};
    cw = !a[15];
    apply(c, $urandom_range(0, 2));
  endtask : rnd_step

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #(20 * 20000);
    n_errors++;
    end_sim();
  end

  initial begin
    void'($urandom(22));
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    flags <= 9'h180;
    spd   <= {16'h0100, 16'h0010, 16'h0020, 16'h0040};
    // Reset command word holds ramp stop, so lockout shows one cycle only
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    chk({15'h0000, state_q[6]}, 16'h0001, "lockout after reset");
    chk({6'h00, tg_q}, 16'h0001, "reset telegram");
    apply(16'h0406, 0);
    apply(16'h040f, 1);
    @(posedge core_clk);
    flags.fault_event <= 1'b1;
    @(posedge core_clk);
    flags.fault_event <= 1'b0;
    flt = 1'b1;
    apply(16'h040f, 0);
    apply(16'h048f, 0);
    apply(16'h040e, 0);
    apply(16'h040f, 2);
    @(posedge core_clk);
    spd.setpoint <= 16'h8000;
    apply(16'h000f, 0);
    apply(16'h080f, 0);
    u_plc_model.send(16'h240f, 0);
    repeat (40) @(posedge core_clk);
    @(negedge core_clk);
    chk({15'h0000, mop_q >= 16'h0008 && mop_q <= 16'h000b}, 16'h0001, "raise");
    u_plc_model.send(16'h640f, 0);
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    v = mop_q;
    repeat (20) @(posedge core_clk);
    @(negedge core_clk);
    chk(mop_q, v, "both held");
    u_plc_model.send(16'h440f, 0);
    repeat (80) @(posedge core_clk);
    @(negedge core_clk);
    chk(mop_q, 16'h0000, "lower to zero");
    repeat (30) rnd_step();
    @(posedge core_clk);
    tsel <= 10'h014;
    repeat (5) @(posedge core_clk);
    chk({6'h00, tg_q}, 16'h0001, "locked mapping");
    unlock <= 1'b1;
    repeat (3) @(posedge core_clk);
    unlock <= 1'b0;
    t20 = 1'b1;
    chk({6'h00, tg_q}, 16'h0014, "telegram 20");
    apply(16'h800f, 0);
    repeat (30) rnd_step();
    end_sim();
  end
endmodule : drive_control_status_words_tb

/* File: sim/plc_model.sv */
`timescale 1ns/1ps
module plc_model (
  input  logic                               core_clk,
  output logic [drive_words_pkg::WORD_W-1:0] command_word,
  output logic                               command_valid
);
  initial begin
    command_word  = 16'h0000;
    command_valid = 1'b0;
  end

  // One word per call, after an optional delay; released line shows the inverse
  task automatic send(input logic [drive_words_pkg::WORD_W-1:0] w, input int gap);
    repeat (gap) @(posedge core_clk);
    @(posedge core_clk);
    command_word  <= w;
    command_valid <= 1'b1;
    @(posedge core_clk);
    command_valid <= 1'b0;
    command_word  <= ~w;
  endtask : send
endmodule : plc_model

/* File: verilog/drive_control_status_words.sv */
`timescale 1ns/1ps
module drive_control_status_words #(
  parameter int MOP_STEP_CYCLES = drive_words_pkg::MOP_STEP_CYCLES
) (
  input  logic                                 core_clk,
  input  logic                                 rst_n,
  input  logic [drive_words_pkg::WORD_W-1:0]   command_word,
  input  logic                                 command_valid,
  input  logic [drive_words_pkg::TG_W-1:0]     telegram_select,
  input  logic                                 map_unlock,
  input  drive_words_pkg::drive_flags_t        drive_flags,
  input  drive_words_pkg::speed_in_t           speed,
  output logic [drive_words_pkg::WORD_W-1:0]   drive_command_word_one,
  output logic [drive_words_pkg::WORD_W-1:0]   drive_state_word_one,
  output logic [drive_words_pkg::WORD_W-1:0]   speed_setpoint_out,
  output logic [drive_words_pkg::WORD_W-1:0]   motor_potentiometer_value,
  output logic [drive_words_pkg::TG_W-1:0]     active_telegram,
  output logic                                 command_data_set,
  output logic                                 motor_energise
);

  localparam int W = drive_words_pkg::WORD_W;

  function automatic logic [W-1:0] neg_sat(input logic [W-1:0] v);
    if (v == 16'h8000) begin
      neg_sat = 16'h7fff;
    end else begin
      neg_sat = W'(~v + 1'b1);
    end
  endfunction : neg_sat

  ////////////////////////////////////////////////////////////////////////////
  // Reset release
  logic sync1_r;
  logic sync2_r;
  logic rst_sync_n;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else begin
      sync1_r <= 1'b1;
      sync2_r <= sync1_r;
    end
  end

  assign rst_sync_n = sync2_r;

  // Assertions wait one cycle past release so registers hold live values
  logic run_r;

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      run_r <= 1'b0;
    end else begin
      run_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Telegram map
  logic [drive_words_pkg::TG_W-1:0] tg_r;
  logic [drive_words_pkg::TG_W-1:0] tg_nxt;
  drive_words_pkg::map_state_t      map_r;
  drive_words_pkg::map_state_t      map_nxt;
  logic                             is_tg20;
  logic                             ext_on;

  always_comb begin
    tg_nxt  = tg_r;
    map_nxt = map_r;
    if (map_unlock && telegram_select != tg_r) begin
      tg_nxt = telegram_select;
      if (telegram_select == drive_words_pkg::TG_STD20) begin
        case (map_r)
          drive_words_pkg::MAP_STD: map_nxt = drive_words_pkg::MAP_T20_KEPT;
          default:                  map_nxt = map_r;
        endcase
      end else begin
        map_nxt = drive_words_pkg::MAP_STD;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      tg_r  <= drive_words_pkg::TG_RESET;
      map_r <= drive_words_pkg::MAP_STD;
    end else begin
      tg_r  <= tg_nxt;
      map_r <= map_nxt;
    end
  end

  assign is_tg20 = (tg_r == drive_words_pkg::TG_STD20);
  // Bits 11, 13, 14 and state bit 12 stay live unless telegram 20 is fresh
  assign ext_on  = (map_r != drive_words_pkg::MAP_T20_FRESH);

  ////////////////////////////////////////////////////////////////////////////
  // Command word and control flags
  logic [W-1:0] cmd_r;
  logic [W-1:0] cmd_nxt;
  logic         ack_prev_r;
  logic         fault_r;
  logic         fault_nxt;
  logic         lock_r;
  logic         lock_nxt;
  logic         cds_r;
  logic         cds_nxt;
  logic         ack_rise;

  always_comb begin
    // Reserved and unused bits are stored for read-back only
    cmd_nxt   = command_valid ? command_word : cmd_r;
    ack_rise  = cmd_r[drive_words_pkg::CMD_FAULT_ACK] && !ack_prev_r;
    // A new fault wins over an acknowledge in the same cycle
    fault_nxt = drive_flags.fault_event || (fault_r && !ack_rise);
    lock_nxt  = lock_r;
    if (!cmd_r[drive_words_pkg::CMD_ON]) begin
      lock_nxt = 1'b0;
    end
    if (ack_rise && fault_r && cmd_r[drive_words_pkg::CMD_ON]) begin
      lock_nxt = 1'b1;
    end
    cds_nxt = cds_r;
    if (is_tg20) begin
      cds_nxt = cmd_r[drive_words_pkg::CMD_CDS0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cmd_r      <= drive_words_pkg::CMD_RESET;
      ack_prev_r <= 1'b0;
      fault_r    <= 1'b0;
      lock_r     <= drive_words_pkg::LOCK_RESET;
      cds_r      <= 1'b0;
    end else begin
      cmd_r      <= cmd_nxt;
      ack_prev_r <= cmd_r[drive_words_pkg::CMD_FAULT_ACK];
      fault_r    <= fault_nxt;
      lock_r     <= lock_nxt;
      cds_r      <= cds_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Setpoint path
  logic [W-1:0] sp_r;
  logic [W-1:0] sp_nxt;
  logic         mop_raise;
  logic         mop_lower;

  always_comb begin
    sp_nxt = speed.setpoint;
    if (ext_on && !cmd_r[drive_words_pkg::CMD_REVERSE]) begin
      sp_nxt = neg_sat(speed.setpoint);
    end
  end

  assign mop_raise = ext_on && cmd_r[drive_words_pkg::CMD_MOP_UP];
  assign mop_lower = ext_on && cmd_r[drive_words_pkg::CMD_MOP_DOWN];

  motor_potentiometer #(
    .WIDTH       (W),
    .STEP_CYCLES (MOP_STEP_CYCLES),
    .MAX_VALUE   (drive_words_pkg::MOP_MAX)
  ) u_mop (
    .core_clk (core_clk),
    .rst_n    (rst_sync_n),
    .raise    (mop_raise),
    .lower    (mop_lower),
    .setpoint (motor_potentiometer_value)
  );

  drive_words_pkg::speed_flags_t spd_flags;

  speed_monitor u_speed (
    .core_clk (core_clk),
    .rst_n    (rst_sync_n),
    .speed    (speed),
    .flags    (spd_flags)
  );

  ////////////////////////////////////////////////////////////////////////////
  // State word assembly
  logic [W-1:0] st_r;
  logic [W-1:0] st_nxt;
  logic         rdy_start;
  logic         rdy;
  logic         op_en;

  always_comb begin
    rdy_start = drive_flags.supply_ok && drive_flags.init_done;
    rdy       = rdy_start && cmd_r[drive_words_pkg::CMD_ON] && !fault_r && !lock_r
             && cmd_r[drive_words_pkg::CMD_NO_COAST] && cmd_r[drive_words_pkg::CMD_NO_QUICK];
    op_en     = rdy && cmd_r[drive_words_pkg::CMD_ENABLE_OP];
    st_nxt    = '0;
    st_nxt[drive_words_pkg::ST_READY_START] = rdy_start;
    st_nxt[drive_words_pkg::ST_READY]       = rdy;
    st_nxt[drive_words_pkg::ST_OP_ENABLED]  = op_en;
    st_nxt[drive_words_pkg::ST_FAULT]       = fault_r;
    st_nxt[drive_words_pkg::ST_NO_COAST]    = cmd_r[drive_words_pkg::CMD_NO_COAST];
    st_nxt[drive_words_pkg::ST_NO_QUICK]    = cmd_r[drive_words_pkg::CMD_NO_QUICK];
    st_nxt[drive_words_pkg::ST_LOCKOUT]     = lock_r;
    st_nxt[drive_words_pkg::ST_ALARM]       = drive_flags.alarm;
    st_nxt[drive_words_pkg::ST_SPEED_TOL]   = spd_flags.within_tol;
    st_nxt[drive_words_pkg::ST_MASTER_REQ]  = drive_flags.master_req;
    st_nxt[drive_words_pkg::ST_SPEED_REACH] = spd_flags.reached;
    st_nxt[drive_words_pkg::ST_LIMIT_N]     = !drive_flags.limit_reached;
    st_nxt[drive_words_pkg::ST_BRAKE_OPEN]  = ext_on && drive_flags.brake_open;
    st_nxt[drive_words_pkg::ST_OVERTEMP_N]  = !drive_flags.motor_overtemp;
    st_nxt[drive_words_pkg::ST_CLOCKWISE]   = spd_flags.clockwise;
    st_nxt[drive_words_pkg::ST_CDS_OVL]     = is_tg20 ? cds_r
                                                      : !drive_flags.inv_overload;
  end

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st_r <= drive_words_pkg::STATE_RESET;
      sp_r <= drive_words_pkg::SP_RESET;
    end else begin
      st_r <= st_nxt;
      sp_r <= sp_nxt;
    end
  end

  assign drive_command_word_one = cmd_r;
  assign drive_state_word_one   = st_r;
  assign speed_setpoint_out     = sp_r;
  assign active_telegram        = tg_r;
  assign command_data_set       = cds_r;
  assign motor_energise         = st_r[drive_words_pkg::ST_OP_ENABLED];

  ////////////////////////////////////////////////////////////////////////////
  chk_reverse_invert: assert property (@(posedge core_clk) disable iff (!run_r)
    (ext_on && !cmd_r[drive_words_pkg::CMD_REVERSE])
      |=> sp_r == neg_sat($past(speed.setpoint)))
    else $error("setpoint not inverted on reversal");
  chk_kept20_brake: assert property (@(posedge core_clk) disable iff (!run_r)
    (map_r == drive_words_pkg::MAP_T20_KEPT) |=> st_r[drive_words_pkg::ST_BRAKE_OPEN]
      == $past(drive_flags.brake_open))
    else $error("kept telegram 20 lost brake bit");
  chk_enter20_keeps: assert property (@(posedge core_clk) disable iff (!run_r)
    (map_r == drive_words_pkg::MAP_STD && map_unlock
      && telegram_select == drive_words_pkg::TG_STD20)
      |=> map_r == drive_words_pkg::MAP_T20_KEPT)
    else $error("entering telegram 20 lost previous mapping");
  chk_map_locked: assert property (@(posedge core_clk) disable iff (!run_r)
    !map_unlock |=> $stable(tg_r))
    else $error("telegram changed while locked");
  chk_cds_follow: assert property (@(posedge core_clk) disable iff (!run_r)
    (is_tg20 && !map_unlock && $stable(cmd_r) && $stable(tg_r)) |=> ##1
      st_r[drive_words_pkg::ST_CDS_OVL] == $past(cmd_r[drive_words_pkg::CMD_CDS0], 2))
    else $error("data set display wrong");
  chk_fault_sticky: assert property (@(posedge core_clk) disable iff (!run_r)
    drive_flags.fault_event |=> ##1 st_r[drive_words_pkg::ST_FAULT])
    else $error("fault not reported");
  chk_lock_release: assert property (@(posedge core_clk) disable iff (!run_r)
    (!cmd_r[drive_words_pkg::CMD_ON] && !(ack_rise && fault_r)) |=> ##1
      !st_r[drive_words_pkg::ST_LOCKOUT])
    else $error("lockout not released by ramp stop");
  chk_op_needs_en: assert property (@(posedge core_clk) disable iff (!run_r)
    st_r[drive_words_pkg::ST_OP_ENABLED] |-> $past(cmd_r[drive_words_pkg::CMD_ENABLE_OP])
      && st_r[drive_words_pkg::ST_READY])
    else $error("operation enabled without enable bit");
  chk_limit_low: assert property (@(posedge core_clk) disable iff (!run_r)
    drive_flags.limit_reached |=> !st_r[drive_words_pkg::ST_LIMIT_N])
    else $error("limit bit not active low");
  chk_ready_start: assert property (@(posedge core_clk) disable iff (!run_r)
    1'b1 |=> st_r[drive_words_pkg::ST_READY_START]
      == ($past(drive_flags.supply_ok) && $past(drive_flags.init_done)))
    else $error("ready to start bit wrong");
  chk_ready_needs_on: assert property (@(posedge core_clk) disable iff (!run_r)
    st_r[drive_words_pkg::ST_READY]
      |-> $past(cmd_r[drive_words_pkg::CMD_ON]) && !$past(fault_r))
    else $error("ready without on command or with fault");
  chk_coast_mirror: assert property (@(posedge core_clk) disable iff (!run_r)
    1'b1 |=> st_r[drive_words_pkg::ST_NO_COAST]
      == $past(cmd_r[drive_words_pkg::CMD_NO_COAST]))
    else $error("coast stop bit wrong");
  chk_quick_mirror: assert property (@(posedge core_clk) disable iff (!run_r)
    1'b1 |=> st_r[drive_words_pkg::ST_NO_QUICK]
      == $past(cmd_r[drive_words_pkg::CMD_NO_QUICK]))
    else $error("quick stop bit wrong");
  chk_alarm_mirror: assert property (@(posedge core_clk) disable iff (!run_r)
    1'b1 |=> st_r[drive_words_pkg::ST_ALARM] == $past(drive_flags.alarm))
    else $error("alarm bit wrong");
  chk_overtemp_low: assert property (@(posedge core_clk) disable iff (!run_r)
    drive_flags.motor_overtemp |=> !st_r[drive_words_pkg::ST_OVERTEMP_N])
    else $error("overtemperature bit not active low");
  chk_overload_low: assert property (@(posedge core_clk) disable iff (!run_r)
    (!is_tg20 && drive_flags.inv_overload) |=> !st_r[drive_words_pkg::ST_CDS_OVL])
    else $error("overload bit not active low");
  chk_cmd_load: assert property (@(posedge core_clk) disable iff (!run_r)
    command_valid |=> cmd_r == $past(command_word))
    else $error("command word not loaded");

endmodule : drive_control_status_words

/* File: verilog/motor_potentiometer.sv */
`timescale 1ns/1ps
module motor_potentiometer #(
  parameter int                WIDTH       = drive_words_pkg::WORD_W,
  parameter int                STEP_CYCLES = drive_words_pkg::MOP_STEP_CYCLES,
  parameter logic [WIDTH-1:0]  MAX_VALUE   = drive_words_pkg::MOP_MAX
) (
  input  logic             core_clk,
  input  logic             rst_n,
  input  logic             raise,
  input  logic             lower,
  output logic [WIDTH-1:0] setpoint
);

  localparam int CNT_W = $clog2(STEP_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(STEP_CYCLES - 1);

  logic [CNT_W-1:0] div_r;
  logic [CNT_W-1:0] div_nxt;
  logic [WIDTH-1:0] value_r;
  logic [WIDTH-1:0] value_nxt;
  logic             step_en;

  ////////////////////////////////////////////////////////////////////////////
  // Step rate divider and ramp
  always_comb begin
    step_en   = (div_r == CNT_LAST);
    div_nxt   = step_en ? '0 : CNT_W'(div_r + 1'b1);
    value_nxt = value_r;
    if (step_en && raise && !lower && value_r != MAX_VALUE) begin
      value_nxt = WIDTH'(value_r + 1'b1);
    end else if (step_en && lower && !raise && value_r != '0) begin
      value_nxt = WIDTH'(value_r - 1'b1);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_r   <= '0;
      value_r <= drive_words_pkg::MOP_RESET;
    end else begin
      div_r   <= div_nxt;
      value_r <= value_nxt;
    end
  end

  assign setpoint = value_r;

  ////////////////////////////////////////////////////////////////////////////
  chk_mop_raise_step: assert property (@(posedge core_clk) disable iff (!rst_n)
    (step_en && raise && !lower && value_r != MAX_VALUE) |=> value_r == $past(value_r) + 1'b1)
    else $error("potentiometer did not step up");
  chk_mop_lower_step: assert property (@(posedge core_clk) disable iff (!rst_n)
    (step_en && lower && !raise && value_r != '0) |=> value_r == $past(value_r) - 1'b1)
    else $error("potentiometer did not step down");

endmodule : motor_potentiometer

/* File: verilog/speed_monitor.sv */
`timescale 1ns/1ps
module speed_monitor (
  input  logic                          core_clk,
  input  logic                          rst_n,
  input  drive_words_pkg::speed_in_t    speed,
  output drive_words_pkg::speed_flags_t flags
);

  localparam int W = drive_words_pkg::WORD_W;

  logic signed [W:0]              diff;
  logic        [W:0]              diff_abs;
  drive_words_pkg::speed_flags_t  flags_r;
  drive_words_pkg::speed_flags_t  flags_nxt;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    diff      = $signed({speed.setpoint[W-1], speed.setpoint})
              - $signed({speed.actual[W-1], speed.actual});
    diff_abs  = diff[W] ? (W+1)'(-diff) : diff;
    flags_nxt = flags_r;
    flags_nxt.within_tol = (diff_abs <= {1'b0, speed.tolerance});
    flags_nxt.reached    = ($signed(speed.actual) >= $signed(speed.compare));
    // Standstill keeps the last direction
    if (!speed.actual[W-1] && speed.actual != '0) begin
      flags_nxt.clockwise = 1'b1;
    end else if (speed.actual[W-1]) begin
      flags_nxt.clockwise = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_r <= '0;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  assign flags = flags_r;

  ////////////////////////////////////////////////////////////////////////////
  chk_speed_reach_cmp: assert property (@(posedge core_clk) disable iff (!rst_n)
    $past(rst_n) |=> flags_r.reached
      == ($signed($past(speed.actual)) >= $signed($past(speed.compare))))
    else $error("comparison speed flag wrong");
  chk_dir_negative: assert property (@(posedge core_clk) disable iff (!rst_n)
    speed.actual[W-1] |=> !flags_r.clockwise)
    else $error("negative speed reported clockwise");

endmodule : speed_monitor
